/* File: include/tx_pcs_pkg.sv */
/*
  shared types and constants of the transmit pcs front end: word and
  half-word carriers, symbol width modes, buffer sizing.
  assumes one clock: the low-speed parallel clock, with the fabric
  interface clock at exactly the same frequency.
*/
package tx_pcs_pkg;

  // widest fabric word and widest pcs-to-pma half
  localparam int WORD_W = 40;
  localparam int HALF_W = 20;
  localparam int CTRL_W = 4;
  localparam int HCTRL_W = 2;

  // phase compensation buffer sizing
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_LVL_W = 3;
  // words held back after reset before reads may start
  localparam logic [2:0] FIFO_PREFILL = 3'h2;

  // field positions of each symbol width
  localparam int W8_LO_MSB = 7;
  localparam int W8_HI_MSB = 15;
  localparam int W10_LO_MSB = 9;
  localparam int W10_HI_MSB = 19;
  localparam int W16_LO_MSB = 15;
  localparam int W16_HI_MSB = 31;
  localparam int W20_LO_MSB = 19;
  localparam int W20_HI_MSB = 39;

  // values after reset
  localparam logic HALF_SEL_RST = 1'b0;

  // pcs-to-pma width: single width 8/10, double width 16/20
  typedef enum logic [1:0] {
    SYM_W8,
    SYM_W10,
    SYM_W16,
    SYM_W20
  } sym_width_t;

  // fabric word: data and its per-half control bits travel together
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [WORD_W-1:0] data;
  } word_t;

  // one half as handed to the encoder or the serializer
  typedef struct packed {
    logic [HCTRL_W-1:0] ctrl;
    logic [HALF_W-1:0]  data;
  } half_t;

endpackage

/* File: rtl/tx_phase_fifo.sv */
/*
  small show-ahead fifo with registered read data, width and depth as
  parameters, valid and ready on both sides.
  assumes a single clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

module tx_phase_fifo #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 4,
  parameter int LVL_W = 3
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // write side
  input  wire logic             wr_valid,
  output logic                  wr_ready,
  input  wire logic [WIDTH-1:0] wr_data,
  // read side
  output logic                  rd_valid,
  input  wire logic             rd_ready,
  output logic [WIDTH-1:0]      rd_data,
  // words held, read register included
  output logic [LVL_W-1:0]      level
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [LVL_W-1:0] count_reg;
  logic [LVL_W-1:0] count_next;
  logic             wr_ready_reg;
  logic             rd_valid_reg;
  logic [WIDTH-1:0] rd_data_reg;
  logic             push;
  logic             pop;

  assign push = wr_valid && wr_ready_reg;
  assign pop  = (count_reg != '0) && (!rd_valid_reg || rd_ready);

  always_comb begin
    count_next = count_reg + LVL_W'(push) - LVL_W'(pop);
  end

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= wr_data;
    end
  end

  // pointers and fill count
  always_ff @(posedge clk) begin
    if (srst) begin
      wr_ptr_reg   <= '0;
      rd_ptr_reg   <= '0;
      count_reg    <= '0;
      wr_ready_reg <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg    <= count_next;
      wr_ready_reg <= (count_next < LVL_W'(DEPTH));
    end
  end

  // registered read data
  always_ff @(posedge clk) begin
    if (srst) begin
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= '0;
    end else if (pop) begin
      rd_valid_reg <= 1'b1;
      rd_data_reg  <= mem[rd_ptr_reg];
    end else if (rd_ready) begin
      rd_valid_reg <= 1'b0;
    end
  end

  assign wr_ready = wr_ready_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_data  = rd_data_reg;
  assign level    = count_reg + LVL_W'(rd_valid_reg);

  a_fifo_no_overrun : assert property (  // [RULE_01]
    @(posedge clk) disable iff (srst)
    push |-> (count_reg < LVL_W'(DEPTH)))
    else $error("fifo written while holding all its words");

endmodule

`default_nettype wire

/* File: rtl/tx_pcs_fifo_byte_serializer.sv */
/*
  transmit pcs front end: phase compensation buffer or registered
  bypass stage, then the byte serializer, then routing of each half to
  the line encoder or straight to the serializer.
  assumes the fabric interface clock equals clk (0 ppm, same edge) and
  that configuration inputs change only while srst is held.
*/
`timescale 1ns/10ps
`default_nettype none

// Notes on behaviour
// [RULE_01] buffer holds four words before transmit pcs
// [RULE_02] two modes: phase compensation or registered bypass
// [RULE_03] bypass adds exactly one cycle of latency
// [RULE_04] bypass register runs on parallel clock
// [RULE_05] buffer written fabric side, read pcs side
// [RULE_06] data and control cross the buffer together
// [RULE_07] writer keeps clocks at identical frequency
// [RULE_08] serializer halves width, doubles word rate
// [RULE_09] lower half always leaves before upper half
// [RULE_10] 16-bit input gives two 8-bit halves
// [RULE_11] 20-bit input: bits 9:0 then 19:10
// [RULE_12] 32-bit input: bits 15:0 then 31:16
// [RULE_13] 40-bit input gives two 20-bit halves
// [RULE_14] pma width 8/10/16/20, fabric doubles when split
// [RULE_15] halves go to encoder or direct serializer
// [RULE_16] configurer enables splitting above fabric limit
// [RULE_17] all stages follow the single/double width setting; here only the half select uses it, buffer and bypass carry whole words
// [RULE_18] reads wait until buffer holds a margin
// [RULE_19] half toggle clears at reset, low first
module tx_pcs_fifo_byte_serializer (
  // clock and reset
  input  wire logic                   clk,
  input  wire logic                   srst,
  // configuration
  input  wire logic                   bypass_mode,
  input  wire logic                   byte_ser_en,
  input  wire tx_pcs_pkg::sym_width_t sym_width,
  input  wire logic                   enc_sel,
  // fabric write side
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire tx_pcs_pkg::word_t      in_word,
  // pcs output side
  output logic                        enc_valid,
  output logic                        ser_valid,
  output tx_pcs_pkg::half_t           out_half,
  input  wire logic                   out_ready,
  // status
  output logic                        reads_started,
  output logic                        underrun
);

  // buffer path
  logic                                fifo_wr_valid;
  logic                                fifo_wr_ready;
  logic                                fifo_rd_valid;
  logic                                fifo_rd_ready;
  tx_pcs_pkg::word_t                   fifo_rd_word;
  logic [tx_pcs_pkg::FIFO_LVL_W-1:0]   fifo_level;
  logic                                started_reg;
  logic                                underrun_reg;

  // bypass register
  logic                                byp_valid_reg;
  tx_pcs_pkg::word_t                   byp_word_reg;

  // serializer
  logic                                half_sel_reg;
  tx_pcs_pkg::word_t                   cur_word_reg;
  tx_pcs_pkg::half_t                   out_half_reg;
  logic                                enc_valid_reg;
  logic                                ser_valid_reg;
  logic                                out_free;
  logic                                src_valid;
  tx_pcs_pkg::word_t                   src_word;
  logic                                src_take;
  logic                                in_take;

  // selects one half of a word at the configured symbol width
  function automatic tx_pcs_pkg::half_t pick_half(
    input tx_pcs_pkg::word_t      w,
    input logic                   hi,
    input tx_pcs_pkg::sym_width_t m
  );
    tx_pcs_pkg::half_t h;
    h      = '0;
    h.ctrl = hi ? w.ctrl[3:2] : w.ctrl[1:0];
    case (m)
      // [RULE_10] eight-bit halves
      tx_pcs_pkg::SYM_W8: begin
        h.data = hi ? {12'h000, w.data[tx_pcs_pkg::W8_HI_MSB:8]}
                    : {12'h000, w.data[tx_pcs_pkg::W8_LO_MSB:0]};
      end
      // [RULE_11] ten-bit halves
      tx_pcs_pkg::SYM_W10: begin
        h.data = hi ? {10'h000, w.data[tx_pcs_pkg::W10_HI_MSB:10]}
                    : {10'h000, w.data[tx_pcs_pkg::W10_LO_MSB:0]};
      end
      // [RULE_12] sixteen-bit halves
      tx_pcs_pkg::SYM_W16: begin
        h.data = hi ? {4'h0, w.data[tx_pcs_pkg::W16_HI_MSB:16]}
                    : {4'h0, w.data[tx_pcs_pkg::W16_LO_MSB:0]};
      end
      // [RULE_13] twenty-bit halves
      tx_pcs_pkg::SYM_W20: begin
        h.data = hi ? w.data[tx_pcs_pkg::W20_HI_MSB:20]
                    : w.data[tx_pcs_pkg::W20_LO_MSB:0];
      end
      default: begin
        h.data = '0;
      end
    endcase
    return h;
  endfunction

  // [RULE_02] mode picks buffer or bypass register
  assign fifo_wr_valid = in_valid && !bypass_mode;
  assign in_ready      = bypass_mode ? (!byp_valid_reg || src_take)
                                     : fifo_wr_ready;
  assign in_take       = in_valid && in_ready;

  // [RULE_01] four-word phase compensation buffer
  // [RULE_05] fabric writes, pcs side reads
  // [RULE_06] control bits ride with the data
  tx_phase_fifo #(
    .WIDTH ($bits(tx_pcs_pkg::word_t)),
    .DEPTH (tx_pcs_pkg::FIFO_DEPTH),
    .LVL_W (tx_pcs_pkg::FIFO_LVL_W)
  ) u_phase_fifo (
    .clk      (clk),
    .srst     (srst),
    .wr_valid (fifo_wr_valid),
    .wr_ready (fifo_wr_ready),
    .wr_data  (in_word),
    .rd_valid (fifo_rd_valid),
    .rd_ready (fifo_rd_ready),
    .rd_data  (fifo_rd_word),
    .level    (fifo_level)
  );

  // [RULE_18] hold reads until the margin is filled
  always_ff @(posedge clk) begin
    if (srst) begin
      started_reg <= 1'b0;
    end else if (!bypass_mode && fifo_level >= tx_pcs_pkg::FIFO_PREFILL) begin
      started_reg <= 1'b1;
    end
  end

  // sticky underrun: reads started but nothing to send
  always_ff @(posedge clk) begin
    if (srst) begin
      underrun_reg <= 1'b0;
    end else if (!bypass_mode && started_reg && out_free && !half_sel_reg
                 && !fifo_rd_valid) begin
      underrun_reg <= 1'b1;
    end
  end

  // [RULE_03] single stage, one cycle
  // [RULE_04] clocked by the parallel clock
  always_ff @(posedge clk) begin
    if (srst) begin
      byp_valid_reg <= 1'b0;
      byp_word_reg  <= '0;
    end else if (bypass_mode) begin
      if (in_take) begin
        byp_valid_reg <= 1'b1;
        byp_word_reg  <= in_word;
      end else if (src_take) begin
        byp_valid_reg <= 1'b0;
      end
    end else begin
      byp_valid_reg <= 1'b0;
    end
  end

  // source of words for the serializer
  assign src_valid = bypass_mode ? byp_valid_reg
                                 : (fifo_rd_valid && started_reg);
  assign src_word  = bypass_mode ? byp_word_reg : fifo_rd_word;
  assign out_free  = !(enc_valid_reg || ser_valid_reg) || out_ready;
  assign src_take  = out_free && !half_sel_reg && src_valid;
  assign fifo_rd_ready = !bypass_mode && started_reg && out_free
                         && !half_sel_reg;

  // [RULE_19] half toggle, low half after reset
  // [RULE_08] second cycle per word for the high half
  always_ff @(posedge clk) begin
    if (srst) begin
      half_sel_reg <= tx_pcs_pkg::HALF_SEL_RST;
    end else if (out_free) begin
      if (half_sel_reg) begin
        half_sel_reg <= 1'b0;
      end else if (src_take && byte_ser_en) begin
        half_sel_reg <= 1'b1;
      end
    end
  end

  // word held while its high half waits
  always_ff @(posedge clk) begin
    if (srst) begin
      cur_word_reg <= '0;
    end else if (src_take) begin
      cur_word_reg <= src_word;
    end
  end

  // [RULE_09] low half first, high half next
  // [RULE_14] unsplit words pass at the pma width
  // [RULE_17] width setting used only by the half select; buffer and bypass carry whole words
  always_ff @(posedge clk) begin
    if (srst) begin
      out_half_reg <= '0;
    end else if (out_free) begin
      if (half_sel_reg) begin
        out_half_reg <= pick_half(cur_word_reg, 1'b1, sym_width);
      end else if (src_take) begin
        out_half_reg <= pick_half(src_word, 1'b0, sym_width);
      end
    end
  end

  // [RULE_15] route to encoder or directly to serializer
  always_ff @(posedge clk) begin
    if (srst) begin
      enc_valid_reg <= 1'b0;
      ser_valid_reg <= 1'b0;
    end else if (out_free) begin
      enc_valid_reg <= (half_sel_reg || src_take) && enc_sel;
      ser_valid_reg <= (half_sel_reg || src_take) && !enc_sel;
    end
  end

  assign enc_valid     = enc_valid_reg;
  assign ser_valid     = ser_valid_reg;
  assign out_half      = out_half_reg;
  assign reads_started = started_reg;
  assign underrun      = underrun_reg;

  a_bypass_one_cycle : assert property (  // [RULE_03]
    @(posedge clk) disable iff (srst)
    (bypass_mode && in_take) |=> (byp_valid_reg
      && byp_word_reg == $past(in_word)))
    else $error("bypass stage did not hold the word one cycle later");

  a_high_follows_low : assert property (  // [RULE_09]
    @(posedge clk) disable iff (srst)
    (src_take && byte_ser_en) |=> (half_sel_reg
      && cur_word_reg == $past(src_word)))
    else $error("high half not queued after its low half");

  a_high_half_sent : assert property (  // [RULE_09]
    @(posedge clk) disable iff (srst)
    (half_sel_reg && out_free) |=> (!half_sel_reg && out_half_reg
      == pick_half($past(cur_word_reg), 1'b1, sym_width)))
    else $error("high half did not follow its low half");

  a_low_half_sent : assert property (  // [RULE_09]
    @(posedge clk) disable iff (srst)
    src_take |=> (out_half_reg == pick_half($past(src_word), 1'b0,
      sym_width)))
    else $error("first half out is not the low half");

  a_toggle_after_reset : assert property (  // [RULE_19]
    @(posedge clk)
    $fell(srst) |-> !half_sel_reg)
    else $error("half toggle not cleared by reset");

  a_half_rate_input : assert property (  // [RULE_08]
    @(posedge clk) disable iff (srst)
    (src_take && byte_ser_en) |=> !src_take)
    else $error("new word taken while high half pending");

  a_ctrl_with_data : assert property (  // [RULE_06]
    @(posedge clk) disable iff (srst)
    src_take |=> (out_half_reg.ctrl == $past(src_word.ctrl[1:0])))
    else $error("control bits separated from their data");

  a_route_exclusive : assert property (  // [RULE_15]
    @(posedge clk) disable iff (srst)
    (enc_valid_reg |-> enc_sel) and (ser_valid_reg |-> !enc_sel)
      and !(enc_valid_reg && ser_valid_reg))
    else $error("half routed to the wrong destination");

  a_prefill_wait : assert property (  // [RULE_18]
    @(posedge clk) disable iff (srst)
    (!bypass_mode && !started_reg) |-> !src_take)
    else $error("buffer read before its margin filled");

  a_fifo_mode_clock : assert property (  // [RULE_05]
    @(posedge clk) disable iff (srst)
    (!bypass_mode && in_take) |=> !byp_valid_reg)
    else $error("buffer mode word went to the bypass stage");

endmodule

`default_nettype wire

/* File: tb/fabric_source.sv */
/*
  fabric-side word source: sends queued words, holds each one
  until accepted, optionally idles a cycle after each word.
  assumes the write clock is the block's clk (0 ppm).
*/
`timescale 1ns/10ps
`default_nettype none

module fabric_source (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         srst,
  // pacing
  input  wire logic         slow,
  // write side
  output tx_pcs_pkg::word_t in_word,
  output logic              in_valid,
  input  wire logic         in_ready
);
  tx_pcs_pkg::word_t q[$];
  logic              taken;
  logic              idle;

  initial begin
    in_valid = 1'b0;
    in_word  = '0;
    taken    = 1'b0;
    idle     = 1'b0;
  end

  always @(posedge clk) begin
    taken = in_valid && in_ready && !srst;
  end

  always @(negedge clk) begin
    if (taken) begin
      void'(q.pop_front());
    end
    idle = taken && slow;
    if (!idle && q.size() > 0) begin
      in_valid = 1'b1;
      in_word  = q[0];
    end else begin
      in_valid = 1'b0;
      in_word  = ~in_word;
    end
  end
endmodule

`default_nettype wire

/* File: tb/tb_tx_pcs_fifo_byte_serializer.sv */
/*
  testbench of the transmit pcs front end: words from a fabric
  source model, halves checked against widths, order and routing.
  assumes one 100 MHz clock and a synchronous active-high reset.
*/
`timescale 1ns/10ps
`default_nettype none

module tb_tx_pcs_fifo_byte_serializer;
  logic                   clk = 1'b0;
  logic                   srst = 1'b1;
  logic                   bypass_mode = 1'b0;
  logic                   byte_ser_en = 1'b0;
  tx_pcs_pkg::sym_width_t sym_width = tx_pcs_pkg::SYM_W8;
  logic                   enc_sel = 1'b0;
  logic                   in_valid;
  logic                   in_ready;
  tx_pcs_pkg::word_t      in_word;
  logic                   enc_valid;
  logic                   ser_valid;
  tx_pcs_pkg::half_t      out_half;
  logic                   out_ready = 1'b0;
  logic                   reads_started;
  logic                   underrun;
  logic                   slow = 1'b0;
  logic [1:0]             stall = 2'h0;
  int                     bad_count = 0;
  int                     checks = 0;
  int                     cyc = 0;
  int                     acc_n = 0;
  int                     out_n = 0;
  int                     acc_cyc = 0;
  int                     out_cyc = 0;
  tx_pcs_pkg::half_t      expq[$];

  tx_pcs_fifo_byte_serializer dut_u (
    .clk           (clk),
    .srst          (srst),
    .bypass_mode   (bypass_mode),
    .byte_ser_en   (byte_ser_en),
    .sym_width     (sym_width),
    .enc_sel       (enc_sel),
    .in_valid      (in_valid),
    .in_ready      (in_ready),
    .in_word       (in_word),
    .enc_valid     (enc_valid),
    .ser_valid     (ser_valid),
    .out_half      (out_half),
    .out_ready     (out_ready),
    .reads_started (reads_started),
    .underrun      (underrun)
  );

  fabric_source src_u (
    .clk      (clk),
    .srst     (srst),
    .slow     (slow),
    .in_word  (in_word),
    .in_valid (in_valid),
    .in_ready (in_ready)
  );

  always #5 clk = ~clk;

  task automatic conclude;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic check_eq(input string name, input logic [31:0] exp,
                          input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  function automatic tx_pcs_pkg::half_t half_of(tx_pcs_pkg::word_t w,
      logic hi, tx_pcs_pkg::sym_width_t m);
    tx_pcs_pkg::half_t h;
    int                sh;
    sh = (m == tx_pcs_pkg::SYM_W8) ? 8 : (m == tx_pcs_pkg::SYM_W10) ? 10 :
         (m == tx_pcs_pkg::SYM_W16) ? 16 : 20;
    h.data = 20'((w.data >> (hi ? sh : 0)) & ((40'h1 << sh) - 40'h1));
    h.ctrl = hi ? w.ctrl[3:2] : w.ctrl[1:0];
    return h;
  endfunction

  // monitors of both sides
  always @(posedge clk) begin
    tx_pcs_pkg::half_t e;
    cyc <= cyc + 1;
    if (!srst && in_valid && in_ready) begin
      acc_n   <= acc_n + 1;
      acc_cyc <= cyc;
    end
    if (!srst && out_ready && (enc_valid || ser_valid)) begin
      if (out_n == 0)
        out_cyc <= cyc;
      out_n <= out_n + 1;
      e = (expq.size() > 0) ? expq.pop_front() : '1;
      check_eq("out_half", 32'(e), 32'(out_half));
      check_eq("enc_valid", 32'(enc_sel), 32'(enc_valid));
      check_eq("ser_valid", 32'(!enc_sel), 32'(ser_valid));
    end
  end

  always @(negedge clk) begin
    out_ready <= (stall == 2'h0) || (stall == 2'h1 && cyc % 3 != 0);
  end

  task automatic setup(input logic bp, input logic ser, input logic enc,
      input tx_pcs_pkg::sym_width_t m, input logic [1:0] st,
      input logic sl);
    @(negedge clk);
    srst        = 1'b1;
    bypass_mode = bp;
    byte_ser_en = ser;
    enc_sel     = enc;
    sym_width   = m;
    stall       = st;
    slow        = sl;
    expq.delete();
    src_u.q.delete();
    repeat (8) @(negedge clk);
    acc_n = 0;
    out_n = 0;
    srst  = 1'b0;
    check_eq("valid", 0, 32'(enc_valid | ser_valid));
    check_eq("out_half", 0, 32'(out_half));
    check_eq("reads_started", 0, 32'(reads_started));
  endtask

  task automatic push(input int k);
    tx_pcs_pkg::word_t w;
    w.data = 40'h13579BDF02 ^ (40'(k) * 40'h0F1E2D3C4B);
    w.ctrl = 4'(k + 5);
    expq.push_back(half_of(w, 1'b0, sym_width));
    if (byte_ser_en)
      expq.push_back(half_of(w, 1'b1, sym_width));
    src_u.q.push_back(w);
  endtask

  task automatic drain;
    int i;
    for (i = 0; i < 3000 && (expq.size() > 0 || src_u.q.size() > 0); i++)
      @(negedge clk);
    // extra cycles so a stray trailing half is still seen
    repeat (4) @(negedge clk);
    check_eq("pending", 0, 32'(expq.size()));
    if (i >= 3000) begin
      bad_count++;
      conclude();
    end
  endtask

  task automatic t_modes;
    for (int mi = 0; mi < 4; mi++) begin
      for (int b = 0; b < 4; b++) begin
        setup(b[1], b[0], b[1] ^ b[0], tx_pcs_pkg::sym_width_t'(mi),
              2'(mi % 2), mi[1]);
        for (int k = 0; k < 6; k++)
          push(k + mi * 8);
        drain();
        if (!b[1])
          check_eq("reads_started", 1, 32'(reads_started));
      end
    end
  endtask

  task automatic t_latency;
    setup(1'b1, 1'b0, 1'b1, tx_pcs_pkg::SYM_W20, 2'h0, 1'b0);
    push(3);
    drain();
    check_eq("latency", 2, 32'(out_cyc - acc_cyc));
  endtask

  task automatic t_prefill;
    setup(1'b0, 1'b0, 1'b0, tx_pcs_pkg::SYM_W8, 2'h0, 1'b0);
    push(1);
    repeat (12) @(negedge clk);
    check_eq("reads_started", 0, 32'(reads_started));
    check_eq("early_out", 0, 32'(out_n));
    push(2);
    drain();
    repeat (6) @(negedge clk);
    check_eq("underrun", 1, 32'(underrun));
  endtask

  task automatic t_full;
    setup(1'b0, 1'b1, 1'b1, tx_pcs_pkg::SYM_W16, 2'h2, 1'b0);
    for (int k = 0; k < 10; k++)
      push(k + 40);
    repeat (30) @(negedge clk);
    check_eq("refused", 1, 32'(acc_n < 10));
    check_eq("held", 1, 32'(acc_n >= tx_pcs_pkg::FIFO_DEPTH));
    stall = 2'h1;
    drain();
  endtask

  initial begin
    t_modes();
    t_latency();
    t_prefill();
    t_full();
    conclude();
  end
endmodule

`default_nettype wire
